/* hw/bfg_defines.vh */
// Operation
// R01: After a trip, retrip; if that fails, trip the upstream breaker.
// R02: Retrip output can be disabled for single-coil breakers.
// R03: Triggers: phase current, residual current, relay outputs, binary signals.
// R04: Current modes check three phases and chosen residual each cycle.
// R05: Signal modes take any binary signal as trigger.
// R06: Output modes watch selected relay control signals.
// R07: Comparisons use fundamental-frequency magnitudes only.
// R08: Residual source: input one, input two or computed residual.
// R09: Selections and forcing are static; setting groups do not touch them.
// R10: Signal mask picks trip events; used only in signal modes.
// R11: Relay mask picks relays; used only in output modes.
// R12: Force status to normal/start/retrip/failure/blocked under stage forcing.
// R13: Picked-up element releases below 97 percent of threshold.
// R14: Blocking at pick-up reports blocked; active start resets and releases.
// R15: One pick-up starts retrip and failure timers together.
// R16: Combine conditions by the selected mode's AND/OR structure.
`ifndef BFG_DEFINES_VH
`define BFG_DEFINES_VH

// Register addresses
`define BFG_ADDR_CTRL 4'h0
`define BFG_ADDR_ISET 4'h1
`define BFG_ADDR_I0SET 4'h2
`define BFG_ADDR_SIGMASK 4'h3
`define BFG_ADDR_DOMASK 4'h4
`define BFG_ADDR_RETRIP_T 4'h5
`define BFG_ADDR_FAIL_T 4'h6
`define BFG_ADDR_COND 4'h7
`define BFG_ADDR_IRQ_STAT 4'h8
`define BFG_ADDR_IRQ_CLR 4'h9
`define BFG_ADDR_IRQ_EN 4'ha

// CTRL fields
`define BFG_CTRL_MODE_LSB 0
`define BFG_CTRL_MODE_MSB 3
`define BFG_CTRL_RSEL_LSB 4
`define BFG_CTRL_RSEL_MSB 5
`define BFG_CTRL_RETRIP_EN 6
`define BFG_CTRL_FORCE_LSB 7
`define BFG_CTRL_FORCE_MSB 9

// Reset values
`define BFG_CTRL_RST 10'h040
`define BFG_ISET_RST 16'h0014
`define BFG_I0SET_RST 16'h04b0
`define BFG_RETRIP_T_RST 16'h000a
`define BFG_FAIL_T_RST 16'h0014

// Activation modes
`define BFG_MODE_CUR 4'h0
`define BFG_MODE_DO 4'h1
`define BFG_MODE_SIG 4'h2
`define BFG_MODE_CUR_AND_DO 4'h3
`define BFG_MODE_CUR_OR_DO 4'h4
`define BFG_MODE_CUR_AND_SIG 4'h5
`define BFG_MODE_CUR_OR_SIG 4'h6
`define BFG_MODE_SIG_AND_DO 4'h7
`define BFG_MODE_SIG_OR_DO 4'h8
`define BFG_MODE_ALL_AND 4'h9
`define BFG_MODE_ALL_OR 4'ha

// Residual source
`define BFG_RSEL_OFF 2'h0
`define BFG_RSEL_ONE 2'h1
`define BFG_RSEL_TWO 2'h2
`define BFG_RSEL_CALC 2'h3

// Forced status codes
`define BFG_FORCE_NORMAL 3'h0
`define BFG_FORCE_START 3'h1
`define BFG_FORCE_RETRIP 3'h2
`define BFG_FORCE_FAIL 3'h3
`define BFG_FORCE_BLOCKED 3'h4

// Release ratio, percent
`define BFG_RELEASE_PCT 7'h61
`define BFG_FULL_PCT 7'h64

`endif

/* hw/bfg_level_cmp.v */
`timescale 1ns/1ps
`include "bfg_defines.vh"

module bfg_level_cmp #(
    parameter W = 16
) (
    input wire mclk_in,
    input wire arst_n_in,
    input wire tick_in,
    input wire enable_in,
    input wire [W-1:0] mag_in,
    input wire [W-1:0] thr_in,
    output wire picked_out
);

    reg picked_reg;
    reg picked_next;
    wire [W+6:0] mag_scaled;
    wire [W+6:0] thr_scaled;

    // Scaled compare avoids a divider for the release ratio
    assign mag_scaled = mag_in * `BFG_FULL_PCT;
    assign thr_scaled = thr_in * `BFG_RELEASE_PCT;

    // Pick above threshold, hold to release level
    always @* begin
        picked_next = picked_reg;
        if (!enable_in) begin
            picked_next = 1'b0;
        end else if (picked_reg) begin
            picked_next = (mag_scaled >= thr_scaled); // [R13]
        end else begin
            picked_next = (mag_in > thr_in);
        end
    end

    // Evaluated once per program cycle
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            picked_reg <= 1'b0;
        end else if (tick_in) begin
            picked_reg <= picked_next; // [R04]
        end
    end

    assign picked_out = picked_reg;

endmodule

/* hw/bfg_top.v */
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "bfg_defines.vh"

module breaker_failure_guard #(
    parameter W = 16,
    parameter NSIG = 32,
    parameter NDO = 32
) (
    input wire mclk_in,
    input wire arst_n_in,
    input wire cycle_tick_in,
    input wire [W-1:0] phase_a_current_in,
    input wire [W-1:0] phase_b_current_in,
    input wire [W-1:0] phase_c_current_in,
    input wire [W-1:0] residual_input_one_in,
    input wire [W-1:0] residual_input_two_in,
    input wire [W-1:0] computed_residual_in,
    input wire [NSIG-1:0] prot_signals_in,
    input wire [NDO-1:0] relay_ctrl_in,
    input wire block_in,
    input wire stage_force_en_in,
    input wire [3:0] addr_in,
    input wire [31:0] wr_data_in,
    input wire wr_en_in,
    input wire rd_en_in,
    output reg [31:0] rd_data_out,
    output reg start_out,
    output reg retrip_out,
    output reg backup_trip_out,
    output reg blocked_out,
    output reg [4:0] condition_out,
    output reg irq_out
);

    // One-hot states
    localparam [4:0] ST_NORMAL = 5'h01;
    localparam [4:0] ST_START = 5'h02;
    localparam [4:0] ST_RETRIP = 5'h04;
    localparam [4:0] ST_FAIL = 5'h08;
    localparam [4:0] ST_BLOCKED = 5'h10;

    // Static settings and interrupt status
    reg [9:0] ctrl_reg; // [R09]
    reg [W-1:0] iset_reg;
    reg [W-1:0] i0set_reg;
    reg [NSIG-1:0] sig_mask_reg;
    reg [NDO-1:0] do_mask_reg;
    reg [15:0] retrip_t_reg;
    reg [15:0] fail_t_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_en_reg;

    // Pin synchronisers
    reg [NSIG-1:0] sig_s1_reg;
    reg [NSIG-1:0] sig_s2_reg;
    reg [NDO-1:0] do_s1_reg;
    reg [NDO-1:0] do_s2_reg;
    reg [1:0] blk_s_reg;
    reg [1:0] frc_s_reg;

    // Supervision state
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [15:0] retrip_cnt_reg;
    reg [15:0] retrip_cnt_next;
    reg [15:0] fail_cnt_reg;
    reg [15:0] fail_cnt_next;

    wire [3:0] mode;
    wire [1:0] rsel;
    wire retrip_en;
    wire [2:0] force_sel;
    wire force_active;
    wire pa_pick;
    wire pb_pick;
    wire pc_pick;
    wire res_pick;
    reg [W-1:0] res_mag;
    wire cur_cond;
    wire sig_cond;
    wire do_cond;
    reg pickup;
    wire retrip_due;
    wire fail_due;
    reg [4:0] shown_state;
    wire [3:0] events;
    wire clr_hit;
    wire [3:0] clr_bits;

    assign mode = ctrl_reg[`BFG_CTRL_MODE_MSB:`BFG_CTRL_MODE_LSB];
    assign rsel = ctrl_reg[`BFG_CTRL_RSEL_MSB:`BFG_CTRL_RSEL_LSB];
    assign retrip_en = ctrl_reg[`BFG_CTRL_RETRIP_EN];
    assign force_sel = ctrl_reg[`BFG_CTRL_FORCE_MSB:`BFG_CTRL_FORCE_LSB];
    assign force_active = frc_s_reg[1];

    // Only the second stage is read
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sig_s1_reg <= {NSIG{1'b0}};
            sig_s2_reg <= {NSIG{1'b0}};
            do_s1_reg <= {NDO{1'b0}};
            do_s2_reg <= {NDO{1'b0}};
            blk_s_reg <= 2'h0;
            frc_s_reg <= 2'h0;
        end else begin
            sig_s1_reg <= prot_signals_in;
            sig_s2_reg <= sig_s1_reg;
            do_s1_reg <= relay_ctrl_in;
            do_s2_reg <= do_s1_reg;
            blk_s_reg <= {blk_s_reg[0], block_in};
            frc_s_reg <= {frc_s_reg[0], stage_force_en_in};
        end
    end

    // Residual source selection
    always @* begin
        case (rsel)
            `BFG_RSEL_ONE: res_mag = residual_input_one_in; // [R08]
            `BFG_RSEL_TWO: res_mag = residual_input_two_in; // [R08]
            `BFG_RSEL_CALC: res_mag = computed_residual_in; // [R08]
            default: res_mag = {W{1'b0}};
        endcase
    end

    // Three phases share one threshold
    bfg_level_cmp #(.W(W)) u_cmp_a (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .tick_in(cycle_tick_in),
        .enable_in(1'b1),
        .mag_in(phase_a_current_in), // [R07]
        .thr_in(iset_reg),
        .picked_out(pa_pick)
    );

    bfg_level_cmp #(.W(W)) u_cmp_b (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .tick_in(cycle_tick_in),
        .enable_in(1'b1),
        .mag_in(phase_b_current_in),
        .thr_in(iset_reg),
        .picked_out(pb_pick)
    );

    bfg_level_cmp #(.W(W)) u_cmp_c (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .tick_in(cycle_tick_in),
        .enable_in(1'b1),
        .mag_in(phase_c_current_in),
        .thr_in(iset_reg),
        .picked_out(pc_pick)
    );

    bfg_level_cmp #(.W(W)) u_cmp_res (
        .mclk_in(mclk_in),
        .arst_n_in(arst_n_in),
        .tick_in(cycle_tick_in),
        .enable_in(rsel != `BFG_RSEL_OFF),
        .mag_in(res_mag),
        .thr_in(i0set_reg),
        .picked_out(res_pick)
    );

    // Trigger source conditions
    assign cur_cond = pa_pick | pb_pick | pc_pick | res_pick; // [R03] [R04]
    assign sig_cond = |(sig_s2_reg & sig_mask_reg); // [R05]
    assign do_cond = |(do_s2_reg & do_mask_reg); // [R06]

    // Masks only count where the mode names their source
    always @* begin
        case (mode)
            `BFG_MODE_CUR: pickup = cur_cond; // [R16]
            `BFG_MODE_DO: pickup = do_cond; // [R11]
            `BFG_MODE_SIG: pickup = sig_cond; // [R10]
            `BFG_MODE_CUR_AND_DO: pickup = cur_cond & do_cond;
            `BFG_MODE_CUR_OR_DO: pickup = cur_cond | do_cond;
            `BFG_MODE_CUR_AND_SIG: pickup = cur_cond & sig_cond;
            `BFG_MODE_CUR_OR_SIG: pickup = cur_cond | sig_cond;
            `BFG_MODE_SIG_AND_DO: pickup = sig_cond & do_cond;
            `BFG_MODE_SIG_OR_DO: pickup = sig_cond | do_cond;
            `BFG_MODE_ALL_AND: pickup = cur_cond & sig_cond & do_cond;
            `BFG_MODE_ALL_OR: pickup = cur_cond | sig_cond | do_cond;
            default: pickup = 1'b0; // Unused codes never trigger
        endcase
    end

    // Timers count program cycles
    assign retrip_due = (retrip_cnt_reg >= retrip_t_reg);
    assign fail_due = (fail_cnt_reg >= fail_t_reg);

    // Supervision, once per program cycle
    always @* begin
        state_next = state_reg;
        retrip_cnt_next = retrip_cnt_reg;
        fail_cnt_next = fail_cnt_reg;
        if (cycle_tick_in) begin
            if (!pickup) begin
                state_next = ST_NORMAL;
                retrip_cnt_next = 16'h0;
                fail_cnt_next = 16'h0;
            end else if (blk_s_reg[1]) begin
                // Blocked pick-up drops any running start
                state_next = ST_BLOCKED; // [R14]
                retrip_cnt_next = 16'h0;
                fail_cnt_next = 16'h0;
            end else begin
                case (state_reg)
                    ST_NORMAL, ST_BLOCKED: begin
                        state_next = ST_START;
                        retrip_cnt_next = 16'h1; // [R15]
                        fail_cnt_next = 16'h1; // [R15]
                    end
                    ST_START, ST_RETRIP: begin
                        if (retrip_cnt_reg != 16'hffff) begin
                            retrip_cnt_next = retrip_cnt_reg + 16'h1;
                        end
                        if (fail_cnt_reg != 16'hffff) begin
                            fail_cnt_next = fail_cnt_reg + 16'h1;
                        end
                        if (fail_due) begin
                            state_next = ST_FAIL; // [R01]
                        end else if (retrip_due && retrip_en) begin
                            state_next = ST_RETRIP; // [R01] [R02]
                        end
                    end
                    ST_FAIL: state_next = ST_FAIL;
                    default: state_next = ST_NORMAL;
                endcase
            end
        end
    end

    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= ST_NORMAL;
            retrip_cnt_reg <= 16'h0;
            fail_cnt_reg <= 16'h0;
        end else begin
            state_reg <= state_next;
            retrip_cnt_reg <= retrip_cnt_next;
            fail_cnt_reg <= fail_cnt_next;
        end
    end

    // Forcing redraws shown status only
    always @* begin
        shown_state = state_reg;
        if (force_active) begin
            case (force_sel)
                `BFG_FORCE_NORMAL: shown_state = ST_NORMAL; // [R12]
                `BFG_FORCE_START: shown_state = ST_START;
                `BFG_FORCE_RETRIP: shown_state = ST_RETRIP;
                `BFG_FORCE_FAIL: shown_state = ST_FAIL;
                `BFG_FORCE_BLOCKED: shown_state = ST_BLOCKED;
                default: shown_state = state_reg;
            endcase
        end
    end

    // Registered outputs; retrip stays quiet when disabled, even forced
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_out <= 1'b0;
            retrip_out <= 1'b0;
            backup_trip_out <= 1'b0;
            blocked_out <= 1'b0;
            condition_out <= ST_NORMAL;
        end else begin
            start_out <= (shown_state != ST_NORMAL) && (shown_state != ST_BLOCKED);
            retrip_out <= (shown_state == ST_RETRIP) && retrip_en; // [R02]
            backup_trip_out <= (shown_state == ST_FAIL); // [R01]
            blocked_out <= (shown_state == ST_BLOCKED);
            condition_out <= shown_state;
        end
    end

    // Events on entry: start, retrip, failure, blocked
    assign events = {state_next[4] & ~state_reg[4],
                     state_next[3] & ~state_reg[3],
                     state_next[2] & ~state_reg[2],
                     state_next[1] & ~state_reg[1]};
    assign clr_hit = wr_en_in && (addr_in == `BFG_ADDR_IRQ_CLR);
    assign clr_bits = clr_hit ? wr_data_in[3:0] : 4'h0;

    // Register writes; a new event beats a same-cycle clear
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctrl_reg <= `BFG_CTRL_RST;
            iset_reg <= `BFG_ISET_RST;
            i0set_reg <= `BFG_I0SET_RST;
            sig_mask_reg <= {NSIG{1'b0}};
            do_mask_reg <= {NDO{1'b0}};
            retrip_t_reg <= `BFG_RETRIP_T_RST;
            fail_t_reg <= `BFG_FAIL_T_RST;
            irq_en_reg <= 4'h0;
            irq_stat_reg <= 4'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~clr_bits) | events;
            if (wr_en_in) begin
                case (addr_in)
                    `BFG_ADDR_CTRL: ctrl_reg <= wr_data_in[9:0];
                    `BFG_ADDR_ISET: iset_reg <= wr_data_in[W-1:0];
                    `BFG_ADDR_I0SET: i0set_reg <= wr_data_in[W-1:0];
                    `BFG_ADDR_SIGMASK: sig_mask_reg <= wr_data_in[NSIG-1:0]; // [R10]
                    `BFG_ADDR_DOMASK: do_mask_reg <= wr_data_in[NDO-1:0]; // [R11]
                    `BFG_ADDR_RETRIP_T: retrip_t_reg <= wr_data_in[15:0];
                    `BFG_ADDR_FAIL_T: fail_t_reg <= wr_data_in[15:0];
                    `BFG_ADDR_IRQ_EN: irq_en_reg <= wr_data_in[3:0];
                    default: ;
                endcase
            end
        end
    end

    // Level interrupt
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // Read data stand one cycle, zero otherwise
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_out <= 32'h0;
        end else if (rd_en_in) begin
            rd_data_out <= 32'h0;
            case (addr_in)
                `BFG_ADDR_CTRL: rd_data_out[9:0] <= ctrl_reg;
                `BFG_ADDR_ISET: rd_data_out[W-1:0] <= iset_reg;
                `BFG_ADDR_I0SET: rd_data_out[W-1:0] <= i0set_reg;
                `BFG_ADDR_SIGMASK: rd_data_out[NSIG-1:0] <= sig_mask_reg;
                `BFG_ADDR_DOMASK: rd_data_out[NDO-1:0] <= do_mask_reg;
                `BFG_ADDR_RETRIP_T: rd_data_out[15:0] <= retrip_t_reg;
                `BFG_ADDR_FAIL_T: rd_data_out[15:0] <= fail_t_reg;
                `BFG_ADDR_COND: rd_data_out[4:0] <= shown_state;
                `BFG_ADDR_IRQ_STAT: rd_data_out[3:0] <= irq_stat_reg;
                `BFG_ADDR_IRQ_EN: rd_data_out[3:0] <= irq_en_reg;
                default: ;
            endcase
        end else begin
            rd_data_out <= 32'h0;
        end
    end

endmodule

/* sim/bfg_checker.sv */
`timescale 1ns/1ps
module bfg_checker (
    input wire mclk_in,
    input wire arst_n_in,
    input wire cycle_tick_in,
    input wire stage_force_en_in,
    input wire [3:0] addr_in,
    input wire rd_en_in,
    input wire [31:0] rd_data_out,
    input wire start_out,
    input wire retrip_out,
    input wire backup_trip_out,
    input wire blocked_out,
    input wire [4:0] condition_out
);
    reg [5:0] frc_reg;
    wire quiet;

    // Forcing may redraw the status; keep recent history
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frc_reg <= 6'h3f;
        end else begin
            frc_reg <= {frc_reg[4:0], stage_force_en_in};
        end
    end
    assign quiet = ~|frc_reg & ~stage_force_en_in;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);

    // Outputs follow the condition
    a_cond_onehot: assert property ($onehot(condition_out))
        else $error("condition not one-hot");
    a_start_map: assert property (start_out == |condition_out[3:1])
        else $error("start vs condition");
    a_retrip_map: assert property (retrip_out |-> condition_out[2])
        else $error("retrip outside retrip condition");
    a_backup_map: assert property (backup_trip_out == condition_out[3])
        else $error("backup trip vs condition");
    a_blocked_map: assert property (blocked_out == condition_out[4])
        else $error("blocked vs condition");
    a_cond_read: assert property (($past(rd_en_in) && $past(addr_in) == 4'h7) |->
        rd_data_out == {27'h0, condition_out})
        else $error("condition read mismatch");

    // Unforced status moves only with the program cycle
    a_move_on_tick: assert property (($changed(condition_out) && quiet) |->
        ($past(cycle_tick_in) || $past(cycle_tick_in, 2)))
        else $error("condition moved off a program cycle");
    a_fail_after_start: assert property (($rose(backup_trip_out) && quiet) |->
        $past(start_out))
        else $error("backup trip without a running start");
    a_start_from_idle: assert property (($rose(condition_out[1]) && quiet) |->
        ($past(condition_out[0]) || $past(condition_out[4])))
        else $error("start from a wrong condition");
endmodule

bind breaker_failure_guard bfg_checker u_bfg_checker (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .cycle_tick_in(cycle_tick_in),
    .stage_force_en_in(stage_force_en_in), .addr_in(addr_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .start_out(start_out), .retrip_out(retrip_out),
    .backup_trip_out(backup_trip_out), .blocked_out(blocked_out),
    .condition_out(condition_out)
);

/* sim/bfg_breaker_model.sv */
`timescale 1ns/1ps
module bfg_breaker_model (
    input wire mclk_in,
    input wire arst_n_in,
    input wire [15:0] fault_cur_in,
    input wire [2:0] fault_sel_in,
    input wire [31:0] sig_in,
    input wire [31:0] relay_in,
    input wire coil2_ok_in,
    input wire retrip_in,
    input wire backup_in,
    output wire [15:0] phase_a_out,
    output wire [15:0] phase_b_out,
    output wire [15:0] phase_c_out,
    output wire [15:0] res_one_out,
    output wire [15:0] res_two_out,
    output wire [15:0] res_calc_out,
    output wire [31:0] prot_out,
    output wire [31:0] relay_out
);
    reg open_reg;
    wire [15:0] cur;

    // Breaker opens on a working second coil or on upstream backup trip
    always @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            open_reg <= 1'b0;
        end else if (fault_cur_in == 16'h0 && sig_in == 32'h0 && relay_in == 32'h0) begin
            open_reg <= 1'b0;
        end else if ((retrip_in && coil2_ok_in) || backup_in) begin
            open_reg <= 1'b1;
        end
    end

    // Fault current flows on one chosen input until the breaker opens
    assign cur = open_reg ? 16'h0 : fault_cur_in;
    assign phase_a_out = (fault_sel_in == 3'h0) ? cur : 16'h0;
    assign phase_b_out = (fault_sel_in == 3'h1) ? cur : 16'h0;
    assign phase_c_out = (fault_sel_in == 3'h2) ? cur : 16'h0;
    assign res_one_out = (fault_sel_in == 3'h3) ? cur : 16'h0;
    assign res_two_out = (fault_sel_in == 3'h4) ? cur : 16'h0;
    assign res_calc_out = (fault_sel_in == 3'h5) ? cur : 16'h0;
    assign prot_out = open_reg ? 32'h0 : sig_in;
    assign relay_out = open_reg ? 32'h0 : relay_in;
endmodule

/* sim/breaker_failure_guard_tb.sv */
`timescale 1ns/1ps
module breaker_failure_guard_tb;
    reg clk, rst_n, tick, blk, fen, we, re, coil2;
    reg [3:0] addr;
    reg [31:0] wdat, sig, dov;
    reg [15:0] fcur;
    reg [2:0] fsel;
    wire [15:0] ia, ib, ic, r1, r2, rc;
    wire [31:0] prot, rly, rdat;
    wire st, rt, bk, bl, irq;
    wire [4:0] cnd;
    integer n_fail, comparisons, i, j;

    breaker_failure_guard u_breaker_failure_guard (.mclk_in(clk), .arst_n_in(rst_n),
        .cycle_tick_in(tick), .phase_a_current_in(ia), .phase_b_current_in(ib),
        .phase_c_current_in(ic), .residual_input_one_in(r1), .residual_input_two_in(r2),
        .computed_residual_in(rc), .prot_signals_in(prot), .relay_ctrl_in(rly),
        .block_in(blk), .stage_force_en_in(fen), .addr_in(addr), .wr_data_in(wdat),
        .wr_en_in(we), .rd_en_in(re), .rd_data_out(rdat), .start_out(st), .retrip_out(rt),
        .backup_trip_out(bk), .blocked_out(bl), .condition_out(cnd), .irq_out(irq));
    bfg_breaker_model u_bfg_breaker_model (.mclk_in(clk), .arst_n_in(rst_n),
        .fault_cur_in(fcur), .fault_sel_in(fsel), .sig_in(sig), .relay_in(dov),
        .coil2_ok_in(coil2), .retrip_in(rt), .backup_in(bk), .phase_a_out(ia),
        .phase_b_out(ib), .phase_c_out(ic), .res_one_out(r1), .res_two_out(r2),
        .res_calc_out(rc), .prot_out(prot), .relay_out(rly));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function [31:0] rv(input integer a);
        case (a)
            0: rv = 32'h40;
            1: rv = 32'h14;
            2: rv = 32'h4b0;
            5: rv = 32'ha;
            6: rv = 32'h14;
            7: rv = 32'h1;
            default: rv = 32'h0;
        endcase
    endfunction
    function pick(input [3:0] m, input c, input s, input d);
        case (m)
            4'h0: pick = c;
            4'h1: pick = d;
            4'h2: pick = s;
            4'h3: pick = c & d;
            4'h4: pick = c | d;
            4'h5: pick = c & s;
            4'h6: pick = c | s;
            4'h7: pick = s & d;
            4'h8: pick = s | d;
            4'h9: pick = c & s & d;
            4'ha: pick = c | s | d;
            default: pick = 1'b0;
        endcase
    endfunction

    // Helpers
    task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task cond(input [4:0] e);
        chk("condition", {27'h0, e}, {27'h0, cnd});
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task rd(input [3:0] a, input [31:0] e);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk("rd_data", e, rdat);
    endtask
    task tk(input integer n);
        repeat (n) begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            repeat (3) @(posedge clk);
        end
        #1;
    endtask
    task drv(input [15:0] c, input [2:0] s, input [31:0] g, input [31:0] d);
        @(posedge clk);
        fcur <= c;
        fsel <= s;
        sig <= g;
        dov <= d;
    endtask
    task bset(input b);
        @(posedge clk);
        blk <= b;
        repeat (3) @(posedge clk);
    endtask

    task t_reset;
        for (i = 0; i < 12; i = i + 1) rd(i[3:0], rv(i));
        wr(4'h7, 32'h1f);
        rd(4'h7, 32'h1);
    endtask
    task t_release;
        drv(16'd30, 3'h2, 32'h0, 32'h0);
        tk(2);
        cond(5'h02);
        drv(16'd20, 3'h2, 32'h0, 32'h0);
        tk(2);
        cond(5'h02);
        drv(16'd19, 3'h2, 32'h0, 32'h0);
        tk(2);
        cond(5'h01);
    endtask
    // Both timers from one pick-up; irq raised, masked, cleared
    task t_trip;
        wr(4'h5, 32'h3);
        wr(4'h6, 32'h6);
        wr(4'ha, 32'hf);
        drv(16'd30, 3'h1, 32'h0, 32'h0);
        for (i = 1; i <= 8; i = i + 1) begin
            tk(1);
            cond(i < 2 ? 5'h01 : i < 5 ? 5'h02 : i < 8 ? 5'h04 : 5'h08);
            chk("retrip", {31'h0, i > 4 && i < 8}, {31'h0, rt});
        end
        rd(4'h8, 32'h7);
        chk("irq", 32'h1, {31'h0, irq});
        wr(4'ha, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk("irq", 32'h0, {31'h0, irq});
        wr(4'h9, 32'h7);
        rd(4'h8, 32'h0);
        drv(16'd0, 3'h1, 32'h0, 32'h0);
        tk(2);
    endtask
    // Second coil clears fault; no backup trip
    task t_clear;
        @(posedge clk);
        coil2 <= 1'b1;
        drv(16'd30, 3'h0, 32'h0, 32'h0);
        for (i = 1; i <= 10; i = i + 1) begin
            tk(1);
            cond(i < 2 ? 5'h01 : i < 5 ? 5'h02 : i < 7 ? 5'h04 : 5'h01);
        end
        coil2 <= 1'b0;
        drv(16'd0, 3'h0, 32'h0, 32'h0);
    endtask
    task t_noretrip;
        wr(4'h0, 32'h0);
        drv(16'd30, 3'h1, 32'h0, 32'h0);
        for (i = 1; i <= 8; i = i + 1) begin
            tk(1);
            cond(i < 2 ? 5'h01 : i < 8 ? 5'h02 : 5'h08);
        end
        drv(16'd0, 3'h1, 32'h0, 32'h0);
        tk(2);
        wr(4'h0, 32'h40);
        wr(4'h5, 32'ha);
        wr(4'h6, 32'h14);
    endtask
    task t_resid;
        for (i = 0; i < 4; i = i + 1) for (j = 3; j < 6; j = j + 1) begin
            wr(4'h0, 32'h40 | (i << 4));
            drv(16'd1300, j[2:0], 32'h0, 32'h0);
            tk(2);
            cond((i == j - 2) ? 5'h02 : 5'h01);
            drv(16'd0, j[2:0], 32'h0, 32'h0);
            tk(2);
        end
    endtask
    // All modes: single, combined, unmasked triggers
    task t_modes;
        wr(4'h3, 32'h8);
        wr(4'h4, 32'h10);
        for (i = 0; i < 12; i = i + 1) for (j = 0; j < 5; j = j + 1) begin
            wr(4'h0, 32'h40 | i);
            drv((j == 0 || j == 3) ? 16'd30 : 16'd0, 3'h0,
                (j == 1 || j == 3) ? 32'h8 : (j == 4 ? 32'h4 : 32'h0),
                (j == 2 || j == 3) ? 32'h10 : (j == 4 ? 32'h20 : 32'h0));
            tk(3);
            cond(pick(i[3:0], j == 0 || j == 3, j == 1 || j == 3, j == 2 || j == 3)
                ? 5'h02 : 5'h01);
            drv(16'd0, 3'h0, 32'h0, 32'h0);
            tk(3);
        end
        wr(4'h0, 32'h40);
    endtask
    task t_block;
        drv(16'd30, 3'h0, 32'h0, 32'h0);
        bset(1'b1);
        tk(3);
        cond(5'h10);
        bset(1'b0);
        tk(1);
        cond(5'h02);
        bset(1'b1);
        tk(1);
        cond(5'h10);
        drv(16'd0, 3'h0, 32'h0, 32'h0);
        bset(1'b0);
        tk(3);
    endtask
    task t_force;
        @(posedge clk);
        fen <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            wr(4'h0, 32'h40 | (i << 7));
            repeat (4) @(posedge clk);
            #1 cond(5'h01 << i);
        end
        wr(4'h0, 32'h1c0);
        @(posedge clk);
        fen <= 1'b0;
        repeat (4) @(posedge clk);
        #1 cond(5'h01);
        wr(4'h0, 32'h40);
    endtask

    task test_done;
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {rst_n, tick, blk, fen, we, re, coil2} = 7'h0;
        {addr, wdat, sig, dov, fcur, fsel} = 0;
        n_fail = 0;
        comparisons = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_release;
        t_trip;
        t_clear;
        t_noretrip;
        t_resid;
        t_modes;
        t_block;
        t_force;
        test_done;
    end

    // Watchdog
    initial begin
        repeat (50000) @(posedge clk);
        n_fail = n_fail + 1;
        test_done;
    end
endmodule
